/* File: bench/i2cc_peer_model.sv */
module i2cc_peer_model import i2cc_pkg::*; #(
	parameter logic [6:0] ADDR = 7'h2E,
	parameter logic [7:0] RD_BYTE = 8'hC3
) (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_oe_o,
	output logic [23:0] wr_bytes_o
);
	initial begin
		sda_oe_o = 1'b0;
		wr_bytes_o = 24'h000000;
	end
	task automatic rx(output logic [7:0] v);
		repeat (8) @(posedge scl_i) v = {v[6:0], sda_i};
	endtask : rx
	// drive just after the fall so the level is settled long before the master samples
	task automatic ack_slot(input logic a);
		@(negedge scl_i) #1 sda_oe_o = a;
		@(negedge scl_i) #1 sda_oe_o = 1'b0;
	endtask : ack_slot
	always begin : run
		logic [7:0] b;
		@(negedge sda_i iff scl_i === 1'b1);
		rx(b);
		if (b[7:1] == ADDR && b[0]) begin
			@(negedge scl_i) #1 sda_oe_o = 1'b1;
			for (int i = 7; i >= 0; i--) begin
				@(negedge scl_i) #1 sda_oe_o = !RD_BYTE[i];
			end
			@(negedge scl_i) #1 sda_oe_o = 1'b0;
		end else begin
			ack_slot(b[7:1] == ADDR);
			if (b[7:1] == ADDR) begin
				forever begin
					rx(b);
					wr_bytes_o = {wr_bytes_o[15:0], b};
					ack_slot(1'b1);
				end
			end
		end
	end
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			disable run;
			sda_oe_o = 1'b0;
		end
	end
endmodule : i2cc_peer_model

/* File: bench/i2cc_top_monitor.sv */
module i2cc_monitor import i2cc_pkg::*; #(
	parameter int WIN_HALF = 64
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic scl_i,
	input wire logic scl_oe_o,
	input wire logic sda_oe_o,
	input wire logic [23:0] dma_addr_o,
	input wire logic dma_we_o,
	input wire logic dma_re_o,
	input wire logic dma_sram_o
);
	logic [7:0] role_q;
	logic [7:0] div_q;
	int hi_cnt_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			role_q <= RST_ROLE;
			div_q <= RST_CLK_DIV;
		end else if (reg_we_i) begin
			if (reg_addr_i == REG_ROLE) role_q <= reg_wdata_i;
			if (reg_addr_i == REG_CLK_DIV) div_q <= reg_wdata_i;
		end
	end
	// released-clock span; stop to next start is long, so only short spans are bit highs
	always_ff @(posedge clk_i) begin
		if (rst_i || scl_oe_o) hi_cnt_q <= 0;
		else hi_cnt_q <= hi_cnt_q + 1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_scl_period: assert property (
		$rose(scl_oe_o) && hi_cnt_q < 3 * div_q |-> hi_cnt_q == 2 * div_q)
		else $error("serial clock high time wrong");
	chk_slave_no_scl: assert property (
		!role_q[CTL_MASTER] && !$past(role_q[CTL_MASTER]) |-> !scl_oe_o)
		else $error("slave role drives clock");
	chk_slave_sda: assert property (
		!role_q[CTL_MASTER] && $changed(sda_oe_o) |-> !scl_i)
		else $error("slave changed data while clock high");
	chk_we_pulse: assert property (dma_we_o |=> !dma_we_o)
		else $error("write strobe longer than one cycle");
	chk_re_pulse: assert property (dma_re_o |=> !dma_re_o)
		else $error("read strobe longer than one cycle");
	chk_sram_sel: assert property (
		(dma_we_o || dma_re_o) && !role_q[CTL_MAP] |-> dma_sram_o == (dma_addr_o >= SRAM_BASE))
		else $error("space select wrong");
	chk_dma_offset: assert property (
		(dma_we_o || dma_re_o) && !role_q[CTL_MAP] |-> dma_addr_o >= DMA_OFFSET)
		else $error("access below offset");
	chk_win_last: assert property (
		$past(reg_re_i && reg_addr_i == REG_WIN_LAST) |-> !reg_rdata_o[7])
		else $error("window offset bit 7 set");
	cover property (dma_we_o && dma_sram_o);
	cover property ($rose(scl_oe_o));
	cover property (dma_re_o && role_q[CTL_MAP]);
endmodule : i2cc_monitor

bind i2cc_top i2cc_monitor #(.WIN_HALF(WIN_HALF)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
	.reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .scl_oe_o(scl_oe_o),
	.sda_oe_o(sda_oe_o), .dma_addr_o(dma_addr_o), .dma_we_o(dma_we_o),
	.dma_re_o(dma_re_o), .dma_sram_o(dma_sram_o));

/* File: bench/tb.sv */
module tb import i2cc_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_i, reg_we_i, reg_re_i, scl_dn, sda_dn, mdl_oe;
	logic scl_oe, sda_oe, dma_we, dma_re, dma_sram;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, dma_rdata_i, dma_wdata;
	logic [23:0] dma_addr, mdl_bytes;
	logic [33:0] acc_q[$];
	int fails = 0;
	int num_checks = 0;
	wire scl_w = !(scl_oe || scl_dn);
	wire sda_w = !(sda_oe || mdl_oe || sda_dn);
	logic [31:0] rows [13] = '{32'h001F0404, 32'h015C5C5C, 32'h0200FF00, 32'h03010101,
		32'h045AA1A1, 32'h05F1B2B2, 32'h0600C3C3, 32'h07000000, 32'hE000FF00,
		32'hE1808080, 32'hE2D7D7D7, 32'hE3000000, 32'h1000AA00};
	i2cc_top #(.WIN_HALF(64)) dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .dma_addr_o(dma_addr),
		.dma_wdata_o(dma_wdata), .dma_we_o(dma_we), .dma_re_o(dma_re),
		.dma_sram_o(dma_sram), .dma_rdata_i(dma_rdata_i));
	i2cc_peer_model peer (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(mdl_oe),
		.wr_bytes_o(mdl_bytes));
	always @(negedge clk_i) begin
		if (dma_we || dma_re) acc_q.push_back({dma_we, dma_sram, dma_addr, dma_we ? dma_wdata : 8'h00});
	end
	always @(posedge clk_i) begin
		if (dma_re) dma_rdata_i <= dma_addr[7:0] ^ 8'h3C;
	end
	task automatic report_and_stop();
		if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic chk_acc(input logic [33:0] e);
		chk("dma access", e, acc_q.size() > 0 ? acc_q.pop_front() : 34'h0);
	endtask : chk_acc
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wt
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		// read data stand only in this cycle; take them mid-cycle
		@(negedge clk_i);
		d = reg_rdata_o;
	endtask : reg_rd
	task automatic wait_idle();
		logic [7:0] d;
		d = 8'hFF;
		wt(4);
		for (int n = 0; n < 3000 && d[ST_PKT] !== 1'b0; n++) reg_rd(REG_STATUS, d);
		chk("packet idle", 1'b0, d[ST_PKT]);
	endtask : wait_idle
	// 32 cycles a bit keeps the bit rate far under a tenth of the clock
	task automatic bit_io(input logic b, output logic s);
		sda_dn <= !b;
		wt(8);
		scl_dn <= 1'b0;
		wt(8);
		s = sda_w;
		wt(8);
		scl_dn <= 1'b1;
		wt(8);
	endtask : bit_io
	task automatic start();
		sda_dn <= 1'b0;
		wt(8);
		scl_dn <= 1'b0;
		wt(8);
		sda_dn <= 1'b1;
		wt(8);
		scl_dn <= 1'b1;
		wt(8);
	endtask : start
	task automatic stop();
		sda_dn <= 1'b1;
		wt(8);
		scl_dn <= 1'b0;
		wt(8);
		sda_dn <= 1'b0;
		wt(8);
	endtask : stop
	task automatic wr_byte(input logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(v[i], s);
		bit_io(1'b1, s);
		chk("slave ack", 1'b0, s);
	endtask : wr_byte
	task automatic rd_byte(output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(1'b1, s);
	endtask : rd_byte
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = !clk_i;
	end
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end
	initial begin : main
		logic [7:0] d;
		{rst_i, reg_we_i, reg_re_i, scl_dn, sda_dn} = 5'b10000;
		{reg_addr_i, reg_wdata_i, dma_rdata_i} = 24'h000000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			reg_rd(rows[i][31:24], d);
			chk("reset value", rows[i][23:16], d);
			reg_wr(rows[i][31:24], rows[i][15:8]);
			reg_rd(rows[i][31:24], d);
			chk("readback", rows[i][7:0], d);
		end
		// own address 0x22 keeps the peer model silent in slave role
		reg_wr(REG_TGT_ID, 8'h44);
		start();
		foreach (rows[i]) if (i < 6) wr_byte(i == 0 ? 8'h44 : rows[i][15:8] ^ rows[i][7:0]);
		stop();
		acc_q.delete();
		start();
		wr_byte(8'h44);
		wr_byte(8'h04);
		wr_byte(8'h00);
		wr_byte(8'hCC);
		wr_byte(8'hA5);
		wr_byte(8'h5B);
		stop();
		chk_acc({2'b11, 24'h8400CC, 8'hA5});
		chk_acc({2'b11, 24'h8400CD, 8'h5B});
		start();
		wr_byte(8'h44);
		wr_byte(8'h00);
		wr_byte(8'h00);
		wr_byte(8'h10);
		start();
		wr_byte(8'h45);
		rd_byte(d);
		stop();
		chk_acc({2'b00, 24'h800010, 8'h00});
		chk("dma read", 8'h2C, d);
		reg_wr(REG_ROLE, 8'h05);
		start();
		wr_byte(8'h44);
		wr_byte(8'h11);
		wr_byte(8'h22);
		stop();
		chk_acc({2'b11, 24'h00D780, 8'h11});
		chk_acc({2'b11, 24'h00D781, 8'h22});
		reg_rd(REG_WIN_LAST, d);
		chk("last offset", 8'h01, d);
		start();
		wr_byte(8'h45);
		rd_byte(d);
		stop();
		chk_acc({2'b01, 24'h00D7C0, 8'h00});
		chk("window read", 8'hFC, d);
		reg_rd(REG_WIN_LAST, d);
		chk("last offset", 8'h40, d);
		start();
		wr_byte(8'h44);
		wr_byte(8'h33);
		stop();
		chk_acc({2'b11, 24'h00D780, 8'h33});
		// the serial-peripheral block is absent, so master role here is always legal
		reg_wr(REG_ROLE, 8'h03);
		reg_wr(REG_TGT_ID, 8'h5C);
		reg_wr(REG_LAUNCH, 8'h3F);
		wt(3);
		reg_rd(REG_STATUS, d);
		chk("busy bits", 2'b11, d[1:0]);
		wait_idle();
		chk("bytes sent", 24'hA1B2C3, mdl_bytes);
		reg_rd(REG_STATUS, d);
		chk("status", 3'b000, d[2:0]);
		// split write: start, address and two bytes, then third byte and stop
		reg_wr(REG_LAUNCH, 8'h17);
		wt(600);
		reg_rd(REG_STATUS, d);
		chk("open packet", 2'b10, d[1:0]);
		chk("split first", 24'hC3A1B2, mdl_bytes);
		reg_wr(REG_LAUNCH, 8'h28);
		wait_idle();
		chk("split second", 24'hA1B2C3, mdl_bytes);
		reg_wr(REG_TGT_ID, 8'h90);
		reg_wr(REG_LAUNCH, 8'h31);
		wait_idle();
		reg_rd(REG_STATUS, d);
		chk("no ack", 3'b100, d[2:0]);
		reg_wr(REG_TGT_ID, 8'h5C);
		reg_wr(REG_LAUNCH, 8'hF9);
		wait_idle();
		reg_rd(REG_RW_THIRD, d);
		chk("read byte", 8'hC3, d);
		reg_rd(REG_STATUS, d);
		chk("read status", 3'b000, d[2:0]);
		report_and_stop();
	end
endmodule : tb

/* File: core/i2cc_pkg.sv */
package i2cc_pkg;
	// register offsets
	localparam logic [7:0] REG_CLK_DIV = 8'h00;
	localparam logic [7:0] REG_TGT_ID = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_ROLE = 8'h03;
	localparam logic [7:0] REG_WR_FIRST = 8'h04;
	localparam logic [7:0] REG_WR_SECOND = 8'h05;
	localparam logic [7:0] REG_RW_THIRD = 8'h06;
	localparam logic [7:0] REG_LAUNCH = 8'h07;
	localparam logic [7:0] REG_WIN_LAST = 8'hE0;
	localparam logic [7:0] REG_WIN_LOW = 8'hE1;
	localparam logic [7:0] REG_WIN_MID = 8'hE2;
	localparam logic [7:0] REG_WIN_HIGH = 8'hE3;
	// reset values
	localparam logic [7:0] RST_CLK_DIV = 8'h1F;
	localparam logic [7:0] RST_TGT_ID = 8'h5C;
	localparam logic [7:0] RST_ROLE = 8'h01;
	localparam logic [7:0] RST_WR_FIRST = 8'h5A;
	localparam logic [7:0] RST_WR_SECOND = 8'hF1;
	localparam logic [7:0] RST_RW_THIRD = 8'h00;
	localparam logic [7:0] RST_LAUNCH = 8'h00;
	localparam logic [7:0] RST_WIN_LOW = 8'h80;
	localparam logic [7:0] RST_WIN_MID = 8'hD7;
	localparam logic [7:0] RST_WIN_HIGH = 8'h00;
	// role_control fields
	localparam int CTL_AUTO_INC = 0;
	localparam int CTL_MASTER = 1;
	localparam int CTL_MAP = 2;
	localparam int CTL_W = 4;
	// cycle_launch fields
	localparam int LCH_ID = 0;
	localparam int LCH_B1 = 1;
	localparam int LCH_B2 = 2;
	localparam int LCH_B3 = 3;
	localparam int LCH_START = 4;
	localparam int LCH_STOP = 5;
	localparam int LCH_RD = 6;
	localparam int LCH_ACK = 7;
	// master_status fields
	localparam int ST_BUSY = 0;
	localparam int ST_PKT = 1;
	localparam int ST_NACK = 2;
	// internal address map
	localparam logic [23:0] DMA_OFFSET = 24'h800000;
	localparam logic [23:0] SRAM_BASE = 24'h840000;
	localparam logic [1:0] HDR_BYTES = 2'h3;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [1:0] QTR_LAST = 2'h3;
	localparam logic [1:0] QTR_SAMPLE = 2'h1;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_START = 2'b01,
		M_BYTE = 2'b10,
		M_STOP = 2'b11
	} i2cc_mst_t;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_ADDR = 2'b01,
		S_WR = 2'b10,
		S_RD = 2'b11
	} i2cc_sl_t;
endpackage : i2cc_pkg

/* File: core/i2cc_slave_link.sv */
module i2cc_slave_link import i2cc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic [6:0] own_addr_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [7:0] tx_data_i,
	output logic sda_oe_o,
	output logic stop_o,
	output logic addr_hit_o,
	output logic rw_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic tx_req_o
);
	i2cc_sl_t st_q;
	logic scl_q;
	logic sda_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] txsh_q;
	logic start_w;
	logic stop_w;
	logic rise_w;
	logic fall_w;

	assign start_w = en_i & scl_q & scl_i & sda_q & ~sda_i;
	assign stop_w = en_i & scl_q & scl_i & ~sda_q & sda_i;
	assign rise_w = ~scl_q & scl_i;
	assign fall_w = scl_q & ~scl_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= S_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			txsh_q <= 8'h00;
			sda_oe_o <= 1'b0;
			stop_o <= 1'b0;
			addr_hit_o <= 1'b0;
			rw_o <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_data_o <= 8'h00;
			tx_req_o <= 1'b0;
		end else begin
			stop_o <= stop_w;
			addr_hit_o <= 1'b0;
			rx_valid_o <= 1'b0;
			tx_req_o <= 1'b0;
			if (!en_i || stop_w) begin
				st_q <= S_IDLE;
				sda_oe_o <= 1'b0;
			end else if (start_w) begin
				st_q <= S_ADDR;
				// the start's own falling clock edge brings the count to zero
				bit_q <= 4'hF;
				sda_oe_o <= 1'b0;
			end else if (st_q != S_IDLE && rise_w) begin
				if (bit_q != BIT_ACK) begin
					sh_q <= {sh_q[6:0], sda_i};
				end else if (st_q == S_RD && sda_i) begin
					// master refused: let go until the next start
					st_q <= S_IDLE;
				end else if (st_q == S_RD || (st_q == S_ADDR && rw_o)) begin
					tx_req_o <= 1'b1;
				end
			end else if (st_q != S_IDLE && fall_w) begin
				if (bit_q == BIT_ACK - 4'h1) begin
					bit_q <= BIT_ACK;
					if (st_q == S_ADDR) begin
						if (sh_q[7:1] == own_addr_i) begin
							sda_oe_o <= 1'b1;
							addr_hit_o <= 1'b1;
							rw_o <= sh_q[0];
						end else begin
							st_q <= S_IDLE;
						end
					end else if (st_q == S_WR) begin
						sda_oe_o <= 1'b1;
						rx_valid_o <= 1'b1;
						rx_data_o <= sh_q;
					end else begin
						sda_oe_o <= 1'b0;
					end
				end else if (bit_q == BIT_ACK) begin
					bit_q <= 4'h0;
					if (st_q == S_RD || (st_q == S_ADDR && rw_o)) begin
						st_q <= S_RD;
						txsh_q <= tx_data_i;
						sda_oe_o <= ~tx_data_i[7];
					end else begin
						st_q <= S_WR;
						sda_oe_o <= 1'b0;
					end
				end else begin
					bit_q <= bit_q + 4'h1;
					if (st_q == S_RD) begin
						txsh_q <= {txsh_q[6:0], 1'b0};
						sda_oe_o <= ~txsh_q[6];
					end
				end
			end
		end
	end
endmodule : i2cc_slave_link

/* File: core/i2cc_top.sv */
// How it works
// - slave DMA mode serves external reads and writes with no software help
// - internal address is the three received address bytes plus 0x800000
// - addresses from 0x800000 hit registers, from 0x840000 hit SRAM
// - bytes move one at a time; auto-increment when control bit 0 set
// - control bit 2 selects mapping sub-mode instead of DMA
// - mapping mode uses a 128-byte SRAM window at the three base registers
// - writes fill the first 64 window bytes, reads come from the next 64
// - after each stop, window accesses restart at the start of each half
// - last window offset readable in bits 6:0, updated only at stop
// - control bit 1 makes the block a master, else it is a slave
// - master serial clock is system clock over four times the divider value, a divider of 0 acting as 1
// - master target address is taken from identity register bits 7:1
// - a launch write runs only enabled phases, always in protocol order
// - status bit 0 is high during a phase and clears when it ends
// - status bit 1 rises with start and clears once stop is sent
// - status bit 2 holds the acknowledge of the latest master-sent byte
// - launch 0x3f writes three buffer bytes with ack capture then stops
// - launch 0xf9 reads one byte into the third buffer, acks, stops
// - launch bits: id, byte1, byte2, byte3/read, start, stop, read, ack
// - acknowledge status reads 0 for ack, 1 for no ack
// - in slave role bytes are acknowledged automatically, any time
//
// The address-and-strobe port was left to the implementer.
module i2cc_top import i2cc_pkg::*; #(
	parameter int WIN_HALF = 64
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic [23:0] dma_addr_o,
	output logic [7:0] dma_wdata_o,
	output logic dma_we_o,
	output logic dma_re_o,
	output logic dma_sram_o,
	input wire logic [7:0] dma_rdata_i
);
	if (WIN_HALF < 1 || WIN_HALF > 64) begin : g_chk
		$error("WIN_HALF must be 1 to 64");
	end

	localparam logic [6:0] WIN_TOP = 7'(WIN_HALF - 1);
	localparam logic [6:0] WIN_RD = 7'(WIN_HALF);

	// software registers
	logic [7:0] clk_div_q;
	logic [7:0] tgt_id_q;
	logic [CTL_W-1:0] ctl_q;
	logic [7:0] wr_first_q;
	logic [7:0] wr_second_q;
	logic [7:0] rw_third_q;
	logic [7:0] launch_q;
	logic [7:0] win_low_q;
	logic [7:0] win_mid_q;
	logic [7:0] win_high_q;
	logic [6:0] win_last_q;
	logic [2:0] status_q;
	// slave side
	logic s_sda_oe;
	logic s_stop;
	logic s_hit;
	logic s_rw;
	logic s_rx_valid;
	logic [7:0] s_rx_data;
	logic s_tx_req;
	logic [1:0] hdr_q;
	logic [23:0] acc_q;
	logic [6:0] wr_ptr_q;
	logic [6:0] rd_ptr_q;
	logic [6:0] last_off_q;
	logic [7:0] tx_data_q;
	logic rd_wait_q;
	// master side
	i2cc_mst_t mst_q;
	logic [5:0] pend_q;
	logic [7:0] div_cnt_q;
	logic [1:0] qtr_q;
	logic [3:0] bit_q;
	logic [7:0] msh_q;
	logic rx_mode_q;
	logic m_scl_low_q;
	logic m_sda_low_q;
	logic rx_cap_q;
	logic pin_lvl_q;
	logic tick_w;
	logic [7:0] div_max_w;
	logic launch_wr_w;
	logic [23:0] win_base_w;

	function automatic logic [6:0] win_next(input logic [6:0] p);
		return (p == WIN_TOP) ? 7'h00 : p + 7'h01;
	endfunction : win_next

	function automatic logic [2:0] first_pend(input logic [5:0] p);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (p[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : first_pend

	assign win_base_w = {win_high_q, win_mid_q, win_low_q};
	assign launch_wr_w = reg_we_i && reg_addr_i == REG_LAUNCH;
	assign div_max_w = (clk_div_q == 8'h00) ? 8'h01 : clk_div_q;
	assign tick_w = (div_cnt_q == div_max_w - 8'h01);

	i2cc_slave_link u_link (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(~ctl_q[CTL_MASTER]),
		.own_addr_i(tgt_id_q[7:1]),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.tx_data_i(tx_data_q),
		.sda_oe_o(s_sda_oe),
		.stop_o(s_stop),
		.addr_hit_o(s_hit),
		.rw_o(s_rw),
		.rx_valid_o(s_rx_valid),
		.rx_data_o(s_rx_data),
		.tx_req_o(s_tx_req)
	);

	// register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_div_q <= RST_CLK_DIV;
			tgt_id_q <= RST_TGT_ID;
			ctl_q <= RST_ROLE[CTL_W-1:0];
			wr_first_q <= RST_WR_FIRST;
			wr_second_q <= RST_WR_SECOND;
			launch_q <= RST_LAUNCH;
			win_low_q <= RST_WIN_LOW;
			win_mid_q <= RST_WIN_MID;
			win_high_q <= RST_WIN_HIGH;
		end else if (reg_we_i) begin
			case (reg_addr_i)
				REG_CLK_DIV: clk_div_q <= reg_wdata_i;
				REG_TGT_ID: tgt_id_q <= reg_wdata_i;
				REG_ROLE: ctl_q <= reg_wdata_i[CTL_W-1:0];
				REG_WR_FIRST: wr_first_q <= reg_wdata_i;
				REG_WR_SECOND: wr_second_q <= reg_wdata_i;
				REG_LAUNCH: launch_q <= reg_wdata_i;
				REG_WIN_LOW: win_low_q <= reg_wdata_i;
				REG_WIN_MID: win_mid_q <= reg_wdata_i;
				REG_WIN_HIGH: win_high_q <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// received master byte wins over a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rw_third_q <= RST_RW_THIRD;
		end else if (rx_cap_q) begin
			rw_third_q <= msh_q;
		end else if (reg_we_i && reg_addr_i == REG_RW_THIRD) begin
			rw_third_q <= reg_wdata_i;
		end
	end

	// read port, data in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_re_i) begin
			case (reg_addr_i)
				REG_CLK_DIV: reg_rdata_o <= clk_div_q;
				REG_TGT_ID: reg_rdata_o <= tgt_id_q;
				REG_STATUS: reg_rdata_o <= {5'h00, status_q};
				REG_ROLE: reg_rdata_o <= {4'h0, ctl_q};
				REG_WR_FIRST: reg_rdata_o <= wr_first_q;
				REG_WR_SECOND: reg_rdata_o <= wr_second_q;
				REG_RW_THIRD: reg_rdata_o <= rw_third_q;
				REG_LAUNCH: reg_rdata_o <= launch_q;
				REG_WIN_LAST: reg_rdata_o <= {1'b0, win_last_q};
				REG_WIN_LOW: reg_rdata_o <= win_low_q;
				REG_WIN_MID: reg_rdata_o <= win_mid_q;
				REG_WIN_HIGH: reg_rdata_o <= win_high_q;
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// slave address tracking and window pointers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hdr_q <= 2'h0;
			acc_q <= 24'h000000;
			wr_ptr_q <= 7'h00;
			rd_ptr_q <= 7'h00;
			last_off_q <= 7'h00;
			win_last_q <= 7'h00;
		end else if (s_stop) begin
			wr_ptr_q <= 7'h00;
			rd_ptr_q <= 7'h00;
			if (ctl_q[CTL_MAP]) begin
				win_last_q <= last_off_q;
			end
		end else if (ctl_q[CTL_MAP]) begin
			if (s_rx_valid) begin
				last_off_q <= wr_ptr_q;
				wr_ptr_q <= win_next(wr_ptr_q);
			end else if (s_tx_req) begin
				last_off_q <= WIN_RD + rd_ptr_q;
				rd_ptr_q <= win_next(rd_ptr_q);
			end
		end else begin
			if (s_hit && !s_rw) begin
				hdr_q <= 2'h0;
			end else if (s_rx_valid && hdr_q != HDR_BYTES) begin
				acc_q <= {acc_q[15:0], s_rx_data};
				hdr_q <= hdr_q + 2'h1;
			end else if ((s_rx_valid || s_tx_req) && ctl_q[CTL_AUTO_INC]) begin
				acc_q <= acc_q + 24'h000001;
			end
		end
	end

	// system-side access port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dma_addr_o <= 24'h000000;
			dma_wdata_o <= 8'h00;
			dma_we_o <= 1'b0;
			dma_re_o <= 1'b0;
			dma_sram_o <= 1'b0;
		end else begin
			dma_we_o <= 1'b0;
			dma_re_o <= 1'b0;
			if (ctl_q[CTL_MAP] && (s_rx_valid || s_tx_req)) begin
				dma_we_o <= s_rx_valid;
				dma_re_o <= s_tx_req;
				dma_wdata_o <= s_rx_data;
				dma_addr_o <= win_base_w + {17'h00000, s_rx_valid ? wr_ptr_q : WIN_RD + rd_ptr_q};
				dma_sram_o <= 1'b1;
			end else if (!ctl_q[CTL_MAP] && ((s_rx_valid && hdr_q == HDR_BYTES) || s_tx_req)) begin
				dma_we_o <= s_rx_valid;
				dma_re_o <= s_tx_req;
				dma_wdata_o <= s_rx_data;
				dma_addr_o <= acc_q + DMA_OFFSET;
				dma_sram_o <= (acc_q + DMA_OFFSET) >= SRAM_BASE;
			end
		end
	end

	// fetched byte is ready long before the next falling clock edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_wait_q <= 1'b0;
			tx_data_q <= 8'h00;
		end else begin
			rd_wait_q <= dma_re_o;
			if (rd_wait_q) begin
				tx_data_q <= dma_rdata_i;
			end
		end
	end

	// quarter-bit divider, only counts while a phase runs
	always_ff @(posedge clk_i) begin
		if (rst_i || mst_q == M_IDLE || tick_w) begin
			div_cnt_q <= 8'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01;
		end
	end

	// master phase sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mst_q <= M_IDLE;
			pend_q <= 6'h00;
			qtr_q <= 2'h0;
			bit_q <= 4'h0;
			msh_q <= 8'h00;
			rx_mode_q <= 1'b0;
			m_scl_low_q <= 1'b0;
			m_sda_low_q <= 1'b0;
			rx_cap_q <= 1'b0;
			status_q <= 3'h0;
		end else begin
			rx_cap_q <= 1'b0;
			case (mst_q)
				M_IDLE: begin
					// launches during a running sequence are ignored
					if (launch_wr_w && pend_q == 6'h00 && ctl_q[CTL_MASTER]) begin
						pend_q <= {reg_wdata_i[LCH_STOP], reg_wdata_i[LCH_B3],
							reg_wdata_i[LCH_B2], reg_wdata_i[LCH_B1],
							reg_wdata_i[LCH_ID], reg_wdata_i[LCH_START]};
					end else if (pend_q != 6'h00 && ctl_q[CTL_MASTER]) begin
						pend_q[first_pend(pend_q)] <= 1'b0;
						qtr_q <= 2'h0;
						bit_q <= 4'h0;
						rx_mode_q <= 1'b0;
						status_q[ST_BUSY] <= 1'b1;
						case (first_pend(pend_q))
							3'h0: begin
								mst_q <= M_START;
								status_q[ST_PKT] <= 1'b1;
								m_scl_low_q <= 1'b0;
								m_sda_low_q <= 1'b0;
							end
							3'h5: begin
								mst_q <= M_STOP;
								m_scl_low_q <= 1'b1;
								m_sda_low_q <= 1'b1;
							end
							default: begin
								mst_q <= M_BYTE;
								m_scl_low_q <= 1'b1;
								case (first_pend(pend_q))
									3'h1: msh_q <= {tgt_id_q[7:1], launch_q[LCH_RD]};
									3'h2: msh_q <= wr_first_q;
									3'h3: msh_q <= wr_second_q;
									default: msh_q <= rw_third_q;
								endcase
								if (first_pend(pend_q) == 3'h4 && launch_q[LCH_RD]) begin
									rx_mode_q <= 1'b1;
									m_sda_low_q <= 1'b0;
								end else begin
									m_sda_low_q <= ~(first_pend(pend_q) == 3'h1 ?
										tgt_id_q[7] : first_pend(pend_q) == 3'h2 ?
										wr_first_q[7] : first_pend(pend_q) == 3'h3 ?
										wr_second_q[7] : rw_third_q[7]);
								end
							end
						endcase
					end else if (!ctl_q[CTL_MASTER]) begin
						pend_q <= 6'h00;
						m_scl_low_q <= 1'b0;
						m_sda_low_q <= 1'b0;
					end
				end
				M_START: if (tick_w) begin
					qtr_q <= qtr_q + 2'h1;
					m_sda_low_q <= (qtr_q != 2'h0);
					m_scl_low_q <= (qtr_q == 2'h2);
					if (qtr_q == QTR_LAST) begin
						mst_q <= M_IDLE;
						status_q[ST_BUSY] <= 1'b0;
						m_scl_low_q <= 1'b1;
						m_sda_low_q <= 1'b1;
					end
				end
				M_STOP: if (tick_w) begin
					qtr_q <= qtr_q + 2'h1;
					m_scl_low_q <= 1'b0;
					m_sda_low_q <= (qtr_q == 2'h0);
					if (qtr_q == QTR_LAST) begin
						mst_q <= M_IDLE;
						status_q[ST_BUSY] <= 1'b0;
						status_q[ST_PKT] <= 1'b0;
					end
				end
				M_BYTE: if (tick_w) begin
					qtr_q <= qtr_q + 2'h1;
					// clock high in quarters 1 and 2, data moves while it is low
					m_scl_low_q <= (qtr_q == 2'h2 || qtr_q == QTR_LAST);
					if (qtr_q == QTR_SAMPLE) begin
						if (bit_q == BIT_ACK && !rx_mode_q) begin
							status_q[ST_NACK] <= sda_i;
						end else if (bit_q != BIT_ACK && rx_mode_q) begin
							msh_q <= {msh_q[6:0], sda_i};
						end
					end
					if (qtr_q == QTR_LAST) begin
						bit_q <= bit_q + 4'h1;
						if (bit_q == BIT_ACK) begin
							mst_q <= M_IDLE;
							status_q[ST_BUSY] <= 1'b0;
							rx_cap_q <= rx_mode_q;
							m_sda_low_q <= 1'b0;
						end else if (bit_q == BIT_ACK - 4'h1) begin
							m_sda_low_q <= rx_mode_q & launch_q[LCH_ACK];
						end else if (rx_mode_q) begin
							m_sda_low_q <= 1'b0;
						end else begin
							msh_q <= {msh_q[6:0], 1'b0};
							m_sda_low_q <= ~msh_q[6];
						end
					end
				end
				default: mst_q <= M_IDLE;
			endcase
		end
	end

	// pin stage, open drain: enable pulls low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
			pin_lvl_q <= 1'b0;
		end else begin
			pin_lvl_q <= 1'b0;
			scl_oe_o <= ctl_q[CTL_MASTER] & m_scl_low_q;
			sda_oe_o <= ctl_q[CTL_MASTER] ? m_sda_low_q : s_sda_oe;
		end
	end

	assign scl_o = pin_lvl_q;
	assign sda_o = pin_lvl_q;
endmodule : i2cc_top
